// ===== ppm_port.sv
// What this block does
// R1 - Basic mode moves data between registers and pins directly, no handshake.
// R2 - Basic mode has ports A, B and two separately directed port C nibbles.
// R3 - Basic mode latches written outputs; input reads return live pin levels.
// R4 - A control word with bit 7 set is a mode definition.
// R5 - Basic mode direction bits: 4 port A, 3 C upper, 1 B, 0 C lower.
// R6 - Strobed mode forms two groups, each a data port plus a C nibble.
// R7 - Strobed data ports go either way and are latched both ways.
// R8 - Strobed mode raises a per-group interrupt that software can enable.
// R9 - Bidirectional mode exists only for group A.
// R10 - Bidirectional port A uses five port C bits, latches, interrupts.
// R11 - Any port C bit can be set or cleared by one control write.
// R12 - In handshake modes the bit set/reset sets those ports' interrupt enables.
// R13 - Offsets: 0 port A, 1 port B, 2 port C, 3 control word.
// R14 - Control write with bit 7 clear: bits 3..1 pick the bit, bit 0 value.
// R15 - Reset makes all ports inputs; mode writes clear every output latch.
`include "ppm_defines.svh"
`timescale 1ns/1ps
module ppm_port (
	// Clock and reset.
	input  wire logic               i_clk_sys,
	input  wire logic               i_rst_n,
	// Host register access.
	input  wire logic               i_rd,
	input  wire logic               i_wr,
	input  wire ppm_pkg::ppm_addr_t i_addr,
	input  wire ppm_pkg::ppm_byte_t i_wdata,
	output ppm_pkg::ppm_byte_t      o_rdata,
	output logic                    o_rvalid,
	// Port A pins.
	input  wire ppm_pkg::ppm_byte_t i_pa,
	output ppm_pkg::ppm_byte_t      o_pa,
	output ppm_pkg::ppm_byte_t      o_pa_oe,
	// Port B pins.
	input  wire ppm_pkg::ppm_byte_t i_pb,
	output ppm_pkg::ppm_byte_t      o_pb,
	output ppm_pkg::ppm_byte_t      o_pb_oe,
	// Port C pins.
	input  wire ppm_pkg::ppm_byte_t i_pc,
	output ppm_pkg::ppm_byte_t      o_pc,
	output ppm_pkg::ppm_byte_t      o_pc_oe,
	// Group interrupt requests.
	output logic                    o_irq_a,
	output logic                    o_irq_b
);
	import ppm_pkg::*;

	// ****************************************************************
	// Decoding.
	// ****************************************************************
	function automatic ppm_mode_t mode_a_of(input ppm_byte_t cw);
		if (cw[`PPM_CW_MODE_A_HI])
			return PPM_MODE_BIDIR;
		else if (cw[`PPM_CW_MODE_A_LO])
			return PPM_MODE_STROBED;
		else
			return PPM_MODE_BASIC;
	endfunction : mode_a_of

	function automatic logic hit(input logic stb, input ppm_addr_t a, input ppm_addr_t off);
		return stb && (a == off);
	endfunction : hit

	ppm_byte_t ctrl_ff;
	ppm_byte_t pa_ff;
	ppm_byte_t pb_ff;
	ppm_byte_t pc_ff;
	ppm_byte_t nxt_rdata;
	ppm_byte_t pa_sync;
	ppm_byte_t pb_sync;
	ppm_byte_t pc_sync;
	ppm_byte_t in_a;
	ppm_byte_t in_b;
	ppm_byte_t hs_any;
	ppm_byte_t hs_drv;
	ppm_byte_t hs_in;
	ppm_byte_t hs_val;
	ppm_byte_t io_in;
	ppm_mode_t mode_a;
	logic      b_strobed;
	logic      a_in;
	logic      b_in;
	logic      wr_def;
	logic      wr_bsr;
	logic      a_in_en;
	logic      a_out_en;
	logic      ibf_a;
	logic      obf_n_a;
	logic      intr_a;
	logic      ibf_b;
	logic      obf_n_b;
	logic      intr_b;

	assign mode_a    = mode_a_of(ctrl_ff);
	assign b_strobed = ctrl_ff[`PPM_CW_MODE_B];
	assign a_in      = ctrl_ff[`PPM_CW_DIR_A];
	assign b_in      = ctrl_ff[`PPM_CW_DIR_B];
	assign wr_def    = hit(i_wr, i_addr, `PPM_OFF_CTRL) && i_wdata[`PPM_CW_DEFINE]; // R4
	assign wr_bsr    = hit(i_wr, i_addr, `PPM_OFF_CTRL) && !i_wdata[`PPM_CW_DEFINE]; // R14
	assign a_in_en   = (mode_a == PPM_MODE_BIDIR) || (mode_a == PPM_MODE_STROBED && a_in);
	assign a_out_en  = (mode_a == PPM_MODE_BIDIR) || (mode_a == PPM_MODE_STROBED && !a_in);
	assign io_in     = {{4{ctrl_ff[`PPM_CW_DIR_CU]}}, {4{ctrl_ff[`PPM_CW_DIR_CL]}}}; // R5

	// ****************************************************************
	// Pin synchronisers.
	// ****************************************************************
	ppm_sync u_sync (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_async   ({i_pa, i_pb, i_pc}),
		.o_sync    ({pa_sync, pb_sync, pc_sync})
	);

	// ****************************************************************
	// Handshake groups.
	// ****************************************************************
	// The interrupt enables live in the port C latch, so the bit set/reset reaches them.
	ppm_hs u_hs_a (
		.i_clk_sys  (i_clk_sys),
		.i_rst_n    (i_rst_n),
		.i_init     (wr_def),
		.i_in_en    (a_in_en),
		.i_out_en   (a_out_en),
		.i_inte_in  (pc_ff[`PPM_PC_STB_A]),
		.i_inte_out (pc_ff[`PPM_PC_ACK_A]),
		.i_stb_n    (pc_sync[`PPM_PC_STB_A]),
		.i_ack_n    (pc_sync[`PPM_PC_ACK_A]),
		.i_pins     (pa_sync),
		.i_rd       (hit(i_rd, i_addr, `PPM_OFF_A)),
		.i_wr       (hit(i_wr, i_addr, `PPM_OFF_A)),
		.o_in_data  (in_a),
		.o_ibf      (ibf_a),
		.o_obf_n    (obf_n_a),
		.o_intr     (intr_a)
	); // R7 R8 R10 R12

	ppm_hs u_hs_b (
		.i_clk_sys  (i_clk_sys),
		.i_rst_n    (i_rst_n),
		.i_init     (wr_def),
		.i_in_en    (b_strobed && b_in),
		.i_out_en   (b_strobed && !b_in),
		.i_inte_in  (pc_ff[`PPM_PC_STB_B]),
		.i_inte_out (pc_ff[`PPM_PC_STB_B]),
		.i_stb_n    (pc_sync[`PPM_PC_STB_B]),
		.i_ack_n    (pc_sync[`PPM_PC_STB_B]),
		.i_pins     (pb_sync),
		.i_rd       (hit(i_rd, i_addr, `PPM_OFF_B)),
		.i_wr       (hit(i_wr, i_addr, `PPM_OFF_B)),
		.o_in_data  (in_b),
		.o_ibf      (ibf_b),
		.o_obf_n    (obf_n_b),
		.o_intr     (intr_b)
	); // R6 R7 R8 R12

	// ****************************************************************
	// Port C ownership.
	// ****************************************************************
	always_comb begin
		hs_any = '0;
		hs_drv = '0;
		hs_in  = '0;
		case (mode_a)
			PPM_MODE_STROBED: begin
				hs_any = a_in ? `PPM_MA1I_ANY : `PPM_MA1O_ANY; // R6
				hs_drv = a_in ? `PPM_MA1I_DRV : `PPM_MA1O_DRV;
				hs_in  = a_in ? `PPM_MA1I_IN : `PPM_MA1O_IN;
			end
			PPM_MODE_BIDIR: begin
				hs_any = `PPM_MA2_ANY; // R9 R10
				hs_drv = `PPM_MA2_DRV;
				hs_in  = `PPM_MA2_IN;
			end
			default: begin
				hs_any = '0;
			end
		endcase
		if (b_strobed) begin
			hs_any = hs_any | `PPM_MB_ANY; // R6
			hs_drv = hs_drv | `PPM_MB_DRV;
			hs_in  = hs_in | `PPM_MB_IN;
		end
	end

	assign hs_val = {obf_n_a, 1'b0, ibf_a, 1'b0, intr_a, 1'b0, b_in ? ibf_b : obf_n_b, intr_b};

	// ****************************************************************
	// Register writes.
	// ****************************************************************
	// Every port starts as an input so nothing fights the far side at power-up.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n)
			ctrl_ff <= `PPM_CTRL_RST; // R15
		else if (wr_def)
			ctrl_ff <= i_wdata; // R4 R5
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pa_ff <= `PPM_LATCH_RST;
			pb_ff <= `PPM_LATCH_RST;
		end else if (wr_def) begin
			pa_ff <= `PPM_LATCH_RST; // R15
			pb_ff <= `PPM_LATCH_RST;
		end else begin
			if (hit(i_wr, i_addr, `PPM_OFF_A))
				pa_ff <= i_wdata; // R1 R3 R13
			if (hit(i_wr, i_addr, `PPM_OFF_B))
				pb_ff <= i_wdata; // R1 R3 R13
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n)
			pc_ff <= `PPM_LATCH_RST;
		else if (wr_def)
			pc_ff <= `PPM_LATCH_RST; // R15
		else if (wr_bsr)
			pc_ff[i_wdata[`PPM_BSR_SEL_HI:`PPM_BSR_SEL_LO]] <= i_wdata[`PPM_BSR_VAL]; // R11 R12 R14
		else if (hit(i_wr, i_addr, `PPM_OFF_C))
			pc_ff <= (pc_ff & hs_any) | (i_wdata & ~hs_any); // R1 R13
	end

	// ****************************************************************
	// Pin drive.
	// ****************************************************************
	assign o_pa = pa_ff;
	assign o_pb = pb_ff;
	assign o_pc = (pc_ff & ~hs_drv) | (hs_val & hs_drv);
	// The bidirectional port only drives while the far side acknowledges.
	assign o_pa_oe = (mode_a == PPM_MODE_BIDIR) ? {8{~pc_sync[`PPM_PC_ACK_A]}} : {8{~a_in}}; // R10 R2
	assign o_pb_oe = {8{~b_in}}; // R2
	assign o_irq_a = intr_a; // R8
	assign o_irq_b = intr_b; // R8

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pc_oe
			assign o_pc_oe[gi] = hs_drv[gi] | (~hs_any[gi] & ~io_in[gi]); // R2 R5
		end
	endgenerate

	// ****************************************************************
	// Register reads.
	// ****************************************************************
	always_comb begin
		nxt_rdata = `PPM_RD_NONE;
		case (i_addr)
			`PPM_OFF_A: nxt_rdata = a_in_en ? in_a : (a_in ? pa_sync : pa_ff); // R3 R7
			`PPM_OFF_B: nxt_rdata = (b_strobed && b_in) ? in_b : (b_in ? pb_sync : pb_ff);
			`PPM_OFF_C: nxt_rdata = (hs_in & pc_ff) | (hs_drv & hs_val)
				| (~hs_any & ((io_in & pc_sync) | (~io_in & pc_ff))); // R3
			default:    nxt_rdata = `PPM_RD_NONE;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata  <= `PPM_RD_NONE;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_rd;
			if (i_rd)
				o_rdata <= nxt_rdata; // R13
		end
	end

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	property p_define_clears;
		wr_def |=> (ctrl_ff == $past(i_wdata)) && (pa_ff == '0) && (pb_ff == '0) && (pc_ff == '0);
	endproperty
	a_define_clears: assert property (p_define_clears) else $error("mode write did not apply"); // R4

	property p_bsr;
		wr_bsr |=> pc_ff[$past(i_wdata[`PPM_BSR_SEL_HI:`PPM_BSR_SEL_LO])]
			== $past(i_wdata[`PPM_BSR_VAL]) && ctrl_ff == $past(ctrl_ff);
	endproperty
	a_bsr: assert property (p_bsr) else $error("bit set/reset wrong"); // R14

	property p_basic_out;
		hit(i_wr, i_addr, `PPM_OFF_A) && mode_a == PPM_MODE_BASIC && !a_in
			|=> o_pa == $past(i_wdata) && o_pa_oe == 8'hff;
	endproperty
	a_basic_out: assert property (p_basic_out) else $error("port A latch not driven"); // R1

	property p_live_read;
		hit(i_rd, i_addr, `PPM_OFF_A) && !i_wr && mode_a == PPM_MODE_BASIC && a_in
			|=> o_rvalid && o_rdata == $past(pa_sync);
	endproperty
	a_live_read: assert property (p_live_read) else $error("input read not live"); // R3

	property p_nibble;
		mode_a == PPM_MODE_BASIC && !b_strobed
			|-> o_pc_oe == ~io_in;
	endproperty
	a_nibble: assert property (p_nibble) else $error("port C nibble direction"); // R5

	property p_strobe_irq;
		mode_a == PPM_MODE_STROBED && a_in && ibf_a && pc_sync[`PPM_PC_STB_A]
			&& pc_ff[`PPM_PC_STB_A] && !wr_def && !hit(i_rd, i_addr, `PPM_OFF_A)
			|=> o_irq_a;
	endproperty
	a_strobe_irq: assert property (p_strobe_irq) else $error("strobe gave no request"); // R8

	property p_bidir_group;
		mode_a == PPM_MODE_BIDIR |-> (hs_drv & `PPM_MA2_ANY) == `PPM_MA2_DRV
			&& o_pa_oe == {8{~pc_sync[`PPM_PC_ACK_A]}}
			&& (b_strobed || (hs_any & `PPM_MB_ANY) == `PPM_LATCH_RST);
	endproperty
	a_bidir_group: assert property (p_bidir_group) else $error("bidir group wrong"); // R10

	property p_b_enable;
		b_strobed && wr_bsr && i_wdata[`PPM_BSR_SEL_HI:`PPM_BSR_SEL_LO] == 3'(`PPM_PC_STB_B)
			|=> pc_ff[`PPM_PC_STB_B] == $past(i_wdata[`PPM_BSR_VAL]) && !o_pc_oe[`PPM_PC_STB_B];
	endproperty
	a_b_enable: assert property (p_b_enable) else $error("group B enable not set"); // R12

	property p_port_b;
		hit(i_wr, i_addr, `PPM_OFF_B) ##1 !i_wr ##1 hit(i_rd, i_addr, `PPM_OFF_B) && !b_in && !i_wr
			|=> o_rdata == $past(i_wdata, 3);
	endproperty
	a_port_b: assert property (p_port_b) else $error("port B readback wrong"); // R13

	c_basic_write: cover property (hit(i_wr, i_addr, `PPM_OFF_A) && mode_a == PPM_MODE_BASIC);
	c_strobe_in:   cover property ($rose(ibf_a));
	c_bidir:       cover property (mode_a == PPM_MODE_BIDIR && !obf_n_a);
	c_bsr:         cover property (wr_bsr);
endmodule : ppm_port

// ===== ppm_defines.svh
`ifndef PPM_DEFINES_SVH
`define PPM_DEFINES_SVH

// ********************************************************************
// Register offsets.
// ********************************************************************
`define PPM_OFF_A        2'h0
`define PPM_OFF_B        2'h1
`define PPM_OFF_C        2'h2
`define PPM_OFF_CTRL     2'h3

// ********************************************************************
// Control word fields.
// ********************************************************************
`define PPM_CW_DEFINE    7
`define PPM_CW_MODE_A_HI 6
`define PPM_CW_MODE_A_LO 5
`define PPM_CW_DIR_A     4
`define PPM_CW_DIR_CU    3
`define PPM_CW_MODE_B    2
`define PPM_CW_DIR_B     1
`define PPM_CW_DIR_CL    0
`define PPM_BSR_SEL_HI   3
`define PPM_BSR_SEL_LO   1
`define PPM_BSR_VAL      0

// ********************************************************************
// Reset values.
// ********************************************************************
`define PPM_CTRL_RST     8'h9b
`define PPM_LATCH_RST    8'h00
`define PPM_RD_NONE      8'h00

// ********************************************************************
// Port C handshake line positions.
// ********************************************************************
`define PPM_PC_STB_B     2
`define PPM_PC_STB_A     4
`define PPM_PC_ACK_A     6

// ********************************************************************
// Port C ownership masks: any handshake use, driven by us, sensed by us.
// ********************************************************************
`define PPM_MB_ANY       8'h07
`define PPM_MB_DRV       8'h03
`define PPM_MB_IN        8'h04
`define PPM_MA1I_ANY     8'h38
`define PPM_MA1I_DRV     8'h28
`define PPM_MA1I_IN      8'h10
`define PPM_MA1O_ANY     8'hc8
`define PPM_MA1O_DRV     8'h88
`define PPM_MA1O_IN      8'h40
`define PPM_MA2_ANY      8'hf8
`define PPM_MA2_DRV      8'ha8
`define PPM_MA2_IN       8'h50

`endif

// ===== ppm_pkg.sv
package ppm_pkg;
	typedef logic [7:0] ppm_byte_t;
	typedef logic [1:0] ppm_addr_t;
	typedef enum logic [1:0] {
		PPM_MODE_BASIC   = 2'h0,
		PPM_MODE_STROBED = 2'h1,
		PPM_MODE_BIDIR   = 2'h3
	} ppm_mode_t;
endpackage : ppm_pkg

// ===== ppm_sync.sv
`timescale 1ns/1ps
module ppm_sync (
	// Clock and reset.
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	// Pin levels in and out.
	input  wire logic [23:0] i_async,
	output logic      [23:0] o_sync
);
	import ppm_pkg::*;

	logic [23:0] meta_ff;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_ff <= '0;
			o_sync  <= '0;
		end else begin
			meta_ff <= i_async;
			o_sync  <= meta_ff;
		end
	end
endmodule : ppm_sync

// ===== ppm_hs.sv
`timescale 1ns/1ps
module ppm_hs (
	// Clock and reset.
	input  wire logic            i_clk_sys,
	input  wire logic            i_rst_n,
	// Configuration.
	input  wire logic            i_init,
	input  wire logic            i_in_en,
	input  wire logic            i_out_en,
	input  wire logic            i_inte_in,
	input  wire logic            i_inte_out,
	// Synchronised handshake pins and data.
	input  wire logic            i_stb_n,
	input  wire logic            i_ack_n,
	input  wire ppm_pkg::ppm_byte_t i_pins,
	// Host accesses to the data port.
	input  wire logic            i_rd,
	input  wire logic            i_wr,
	// Status and latched data.
	output ppm_pkg::ppm_byte_t   o_in_data,
	output logic                 o_ibf,
	output logic                 o_obf_n,
	output logic                 o_intr
);
	import ppm_pkg::*;

	logic stb_prev_ff;
	logic ack_prev_ff;
	logic nxt_ibf;
	logic nxt_obf_n;
	logic stb_fall;
	logic ack_fall;

	assign stb_fall = stb_prev_ff & ~i_stb_n;
	assign ack_fall = ack_prev_ff & ~i_ack_n;

	// A strobe that lands in the same cycle as the host read keeps the flag set.
	always_comb begin
		nxt_ibf   = o_ibf;
		nxt_obf_n = o_obf_n;
		if (i_init || !i_in_en)
			nxt_ibf = 1'b0;
		else if (stb_fall)
			nxt_ibf = 1'b1;
		else if (i_rd)
			nxt_ibf = 1'b0;
		if (i_init || !i_out_en)
			nxt_obf_n = 1'b1;
		else if (i_wr)
			nxt_obf_n = 1'b0;
		else if (ack_fall)
			nxt_obf_n = 1'b1;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stb_prev_ff <= 1'b1;
			ack_prev_ff <= 1'b1;
			o_in_data   <= '0;
			o_ibf       <= 1'b0;
			o_obf_n     <= 1'b1;
			o_intr      <= 1'b0;
		end else begin
			stb_prev_ff <= i_stb_n;
			ack_prev_ff <= i_ack_n;
			if (i_in_en && stb_fall)
				o_in_data <= i_pins;
			o_ibf       <= nxt_ibf;
			o_obf_n     <= nxt_obf_n;
			o_intr      <= (i_in_en & nxt_ibf & i_stb_n & i_inte_in)
				| (i_out_en & nxt_obf_n & i_ack_n & i_inte_out);
		end
	end
endmodule : ppm_hs

// ===== ppm_ext_pin.sv
`timescale 1ns/1ps
module ppm_ext_pin (
	// Clock.
	input  wire logic               i_clk_sys,
	// Device drive.
	input  wire ppm_pkg::ppm_byte_t i_dev,
	input  wire ppm_pkg::ppm_byte_t i_dev_oe,
	// Equipment drive.
	input  wire ppm_pkg::ppm_byte_t i_ext,
	input  wire ppm_pkg::ppm_byte_t i_ext_en,
	// Resolved pin level.
	output ppm_pkg::ppm_byte_t      o_wire
);
	import ppm_pkg::*;

	// ****************************************************************
	// Pin resolution.
	// ****************************************************************
	// A floating line toggles every cycle so that no stale level can pass for data.
	ppm_byte_t last_ff = 8'h00;

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			o_wire[i] = i_dev_oe[i] ? i_dev[i] : (i_ext_en[i] ? i_ext[i] : ~last_ff[i]);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		last_ff <= o_wire;
	end
endmodule : ppm_ext_pin

// ===== tb_programmable_parallel_port_modes.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("mismatch %s expected %h seen %h", what, exp, got); end end
module tb_programmable_parallel_port_modes;
	import ppm_pkg::*;

	// ****************************************************************
	// Signals.
	// ****************************************************************
	logic      i_clk_sys;
	logic      i_rst_n;
	logic      i_rd;
	logic      i_wr;
	ppm_addr_t i_addr;
	ppm_byte_t i_wdata;
	ppm_byte_t o_rdata;
	logic      o_rvalid;
	ppm_byte_t o_pa, o_pa_oe, o_pb, o_pb_oe, o_pc, o_pc_oe;
	ppm_byte_t pa_w, pb_w, pc_w;
	ppm_byte_t ext_a, ext_b, ext_c, en_a, en_b, en_c;
	logic      o_irq_a;
	logic      o_irq_b;
	ppm_byte_t cw;
	int        n_mismatch = 0;
	int        compares = 0;
	int        cycles = 0;

	ppm_port u_ppm_port (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_rd(i_rd), .i_wr(i_wr),
		.i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
		.i_pa(pa_w), .o_pa(o_pa), .o_pa_oe(o_pa_oe), .i_pb(pb_w), .o_pb(o_pb),
		.o_pb_oe(o_pb_oe), .i_pc(pc_w), .o_pc(o_pc), .o_pc_oe(o_pc_oe),
		.o_irq_a(o_irq_a), .o_irq_b(o_irq_b));
	ppm_ext_pin u_ppm_ext_pin_a (.i_clk_sys(i_clk_sys), .i_dev(o_pa), .i_dev_oe(o_pa_oe),
		.i_ext(ext_a), .i_ext_en(en_a), .o_wire(pa_w));
	ppm_ext_pin u_ppm_ext_pin_b (.i_clk_sys(i_clk_sys), .i_dev(o_pb), .i_dev_oe(o_pb_oe),
		.i_ext(ext_b), .i_ext_en(en_b), .o_wire(pb_w));
	ppm_ext_pin u_ppm_ext_pin_c (.i_clk_sys(i_clk_sys), .i_dev(o_pc), .i_dev_oe(o_pc_oe),
		.i_ext(ext_c), .i_ext_en(en_c), .o_wire(pc_w));

	// ****************************************************************
	// Clock and timeout.
	// ****************************************************************
	initial begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end

	// The whole sequence needs well under a thousand cycles.
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles >= 5000) begin
			n_mismatch++;
			stop_test();
		end
	end

	// ****************************************************************
	// Tasks.
	// ****************************************************************
	task automatic idle(input int n);
		repeat (n) @(negedge i_clk_sys);
	endtask : idle

	task automatic wr(input ppm_addr_t a, input ppm_byte_t d);
		@(negedge i_clk_sys);
		i_wr = 1'b1;
		i_addr = a;
		i_wdata = d;
		@(negedge i_clk_sys);
		i_wr = 1'b0;
	endtask : wr

	task automatic rchk(input string what, input ppm_addr_t a, input ppm_byte_t exp);
		int k;
		@(negedge i_clk_sys);
		i_rd = 1'b1;
		i_addr = a;
		@(negedge i_clk_sys);
		i_rd = 1'b0;
		k = 0;
		while (o_rvalid !== 1'b1 && k < 4) begin
			@(negedge i_clk_sys);
			k++;
		end
		`CHK("rvalid", 1'b1, o_rvalid);
		`CHK(what, exp, o_rdata);
	endtask : rchk

	// Strobe and acknowledge lines are held low four cycles, past the synchroniser.
	task automatic strobe(input int b);
		ext_c[b] = 1'b0;
		idle(4);
		ext_c[b] = 1'b1;
		idle(6);
	endtask : strobe

	task automatic test_end(input string name);
		$display("test %s done", name);
	endtask : test_end

	task automatic stop_test();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test

	// ****************************************************************
	// Sequence.
	// ****************************************************************
	initial begin
		i_rst_n = 1'b0;
		{i_rd, i_wr, i_addr, i_wdata} = '0;
		{ext_a, ext_b, ext_c, en_a, en_b, en_c} = '0;
		idle(5);
		i_rst_n = 1'b1;
		`CHK("oe after reset", 24'h00_0000, {o_pa_oe, o_pb_oe, o_pc_oe});
		{ext_a, ext_b, ext_c} = {8'ha5, 8'h3c, 8'h5a};
		{en_a, en_b, en_c} = {8'hff, 8'hff, 8'hff};
		idle(3);
		rchk("port a in", 2'h0, 8'ha5);
		rchk("port b in", 2'h1, 8'h3c);
		rchk("port c in", 2'h2, 8'h5a);
		ext_a = 8'h5a;
		idle(3);
		rchk("port a live", 2'h0, 8'h5a);
		rchk("control rd", 2'h3, 8'h00);
		test_end("reset");
		{en_a, en_b, en_c} = '0;
		for (int n = 0; n < 16; n++) begin
			cw = {3'b100, n[3], n[2], 1'b0, n[1], n[0]};
			wr(2'h3, cw);
			`CHK("pa oe", {8{~cw[4]}}, o_pa_oe);
			`CHK("pb oe", {8{~cw[1]}}, o_pb_oe);
			`CHK("pc oe", {{4{~cw[3]}}, {4{~cw[0]}}}, o_pc_oe);
		end
		test_end("mode table");
		wr(2'h3, 8'h80);
		wr(2'h0, 8'h12);
		wr(2'h1, 8'h34);
		rchk("port b latch", 2'h1, 8'h34);
		wr(2'h2, 8'h56);
		`CHK("out latches", 24'h12_3456, {o_pa, o_pb, o_pc});
		rchk("port a latch", 2'h0, 8'h12);
		wr(2'h3, 8'h80);
		`CHK("latch clear", 24'h00_0000, {o_pa, o_pb, o_pc});
		wr(2'h3, 8'h89);
		{ext_c, en_c} = {8'hc3, 8'hff};
		wr(2'h0, 8'h66);
		idle(3);
		rchk("port c mixed", 2'h2, 8'hc3);
		`CHK("pa mixed", 8'h66, pa_w);
		en_c = 8'h00;
		wr(2'h3, 8'h80);
		for (int i = 0; i < 8; i++) begin
			wr(2'h3, {4'h0, i[2:0], 1'b1});
			`CHK("bit set", 8'h01 << i, o_pc);
			wr(2'h3, {4'h0, i[2:0], 1'b0});
			`CHK("bit clear", 8'h00, o_pc);
		end
		test_end("basic");
		{ext_a, en_a, ext_c, en_c} = {8'h3c, 8'hff, 8'hff, 8'hff};
		wr(2'h3, 8'hb0);
		wr(2'h3, 8'h09);
		idle(3);
		strobe(4);
		ext_a = 8'hc3;
		idle(3);
		`CHK("ibf a", 1'b1, o_pc[5]);
		`CHK("irq a", 1'b1, o_irq_a);
		`CHK("intr a", 1'b1, o_pc[3]);
		`CHK("pa oe in", 8'h00, o_pa_oe);
		rchk("port a held", 2'h0, 8'h3c);
		idle(2);
		`CHK("ibf a clear", 1'b0, o_pc[5]);
		`CHK("irq a clear", 1'b0, o_irq_a);
		wr(2'h3, 8'h08);
		strobe(4);
		`CHK("ibf a again", 1'b1, o_pc[5]);
		`CHK("irq a masked", 1'b0, o_irq_a);
		test_end("strobed in");
		wr(2'h3, 8'h84);
		wr(2'h3, 8'h05);
		wr(2'h1, 8'h77);
		`CHK("pb out", 8'h77, pb_w);
		`CHK("pb oe", 8'hff, o_pb_oe);
		idle(1);
		`CHK("obf b low", 1'b0, o_pc[1]);
		`CHK("irq b idle", 1'b0, o_irq_b);
		strobe(2);
		`CHK("obf b high", 1'b1, o_pc[1]);
		`CHK("irq b", 1'b1, o_irq_b);
		`CHK("intr b", 1'b1, o_pc[0]);
		test_end("strobed out");
		{ext_b, en_b} = {8'h4b, 8'hff};
		wr(2'h3, 8'h86);
		wr(2'h3, 8'h05);
		strobe(2);
		`CHK("ibf b", 1'b1, o_pc[1]);
		`CHK("irq b in", 1'b1, o_irq_b);
		rchk("port b in held", 2'h1, 8'h4b);
		test_end("strobed b in");
		wr(2'h3, 8'ha0);
		wr(2'h3, 8'h0d);
		wr(2'h0, 8'h5a);
		`CHK("obf a out low", 1'b0, o_pc[7]);
		`CHK("pa out", 8'h5a, pa_w);
		strobe(6);
		`CHK("irq a out", 1'b1, o_irq_a);
		rchk("port c status", 2'h2, 8'hc8);
		test_end("strobed a out");
		{ext_a, en_a} = {8'h81, 8'hff};
		wr(2'h3, 8'hc0);
		wr(2'h0, 8'h99);
		idle(1);
		`CHK("obf a low", 1'b0, o_pc[7]);
		`CHK("pa released", 8'h00, o_pa_oe);
		en_a = 8'h00;
		ext_c[6] = 1'b0;
		idle(4);
		`CHK("pa driven", 8'hff, o_pa_oe);
		`CHK("pa data", 8'h99, pa_w);
		ext_c[6] = 1'b1;
		idle(4);
		en_a = 8'hff;
		`CHK("obf a high", 1'b1, o_pc[7]);
		strobe(4);
		`CHK("ibf bidir", 1'b1, o_pc[5]);
		rchk("port a bidir", 2'h0, 8'h81);
		test_end("bidirectional");
		stop_test();
	end
endmodule : tb_programmable_parallel_port_modes
